// ### logic/lpmc_pkg.sv
// Purpose: constants and types for the low-power mode controller
// Assumes: one clock, synchronous active-high reset
// Notes: mode selection and wakeup sources arrive as plain pins
package lpmc_pkg;
	localparam int unsigned LPMC_EXT_LINES = 16;
	localparam int unsigned LPMC_WAKE_PINS = 3;
	localparam logic [1:0] LPMC_SEL_HALT = 2'h0;
	localparam logic [1:0] LPMC_SEL_RETAIN = 2'h1;
	localparam logic [1:0] LPMC_SEL_POWERDOWN = 2'h2;
	localparam logic LPMC_RST_REGULATOR_LP = 1'h0;

	typedef enum logic [2:0] {
		LPMC_RUN,
		LPMC_HALT,
		LPMC_RETAIN,
		LPMC_POWERDOWN,
		LPMC_WAKE_RESET
	} lpmc_mode_e;
endpackage

// ### logic/lpmc_edge_detect.sv
// Purpose: rising-edge detection on a vector of wake pins
// Assumes: inputs already synchronous to ref_clk_i
// Notes: one registered stage per bit
`timescale 1ns/100ps
module lpmc_edge_detect #(
	parameter int unsigned WIDTH = 3
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] level_i,
	output logic [WIDTH-1:0] rise_o
);
	typedef struct packed {
		logic [WIDTH-1:0] prev;
	} lpmc_edge_s;
	lpmc_edge_s state;
	lpmc_edge_s next_state;

	// Refused while elaborating, not at run time
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least one");
	end

	always_comb begin
		next_state.prev = level_i;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			state <= '0;
		else
			state <= next_state;
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign rise_o[g] = level_i[g] & ~state.prev[g];
		end
	endgenerate
endmodule // lpmc_edge_detect

// ### logic/lpmc_controller.sv
// Purpose: low-power mode sequencer between core and wakeup sources
// Assumes: all inputs synchronous to ref_clk_i
// Notes: clock, regulator_on and flash outputs are enables; high means the resource runs
`timescale 1ns/100ps
module lpmc_controller #(
	parameter int unsigned EXT_LINES = lpmc_pkg::LPMC_EXT_LINES,
	parameter int unsigned WAKE_PINS = lpmc_pkg::LPMC_WAKE_PINS
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic wait_instr_i,
	input wire logic [1:0] mode_sel_i,
	input wire logic regulator_lp_sel_i,
	input wire logic flash_off_req_i,
	input wire logic exec_from_ram_i,
	input wire logic periph_irq_i,
	input wire logic [EXT_LINES-1:0] ext_event_line_i,
	input wire logic voltage_detector_out_i,
	input wire logic rtc_event_i,
	input wire logic ext_reset_pin_n_i,
	input wire logic independent_watchdog_rst_i,
	input wire logic [WAKE_PINS-1:0] wake_pin_i,
	input wire logic regulator_bypass_i,
	input wire logic main_supply_ok_i,
	input wire logic supervisor_strap_i,
	output logic cpu_clk_en_o,
	output logic periph_clk_en_o,
	output logic pll_en_o,
	output logic internal_fast_rc_en_o,
	output logic crystal_osc_en_o,
	output logic regulator_on_o,
	output logic regulator_lp_o,
	output logic flash_pwr_o,
	output logic retain_ok_o,
	output logic core_reset_o,
	output logic backup_from_battery_o,
	output logic battery_mode_o
);
	import lpmc_pkg::*;

	typedef struct packed {
		lpmc_mode_e mode;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic clk_src_en;
		logic regulator_on;
		logic regulator_lp;
		logic flash_pwr;
		logic retain_ok;
		logic core_reset;
		logic from_battery;
		logic battery_mode;
	} lpmc_ctrl_s;

	lpmc_ctrl_s state;
	lpmc_ctrl_s next_state;
	logic [WAKE_PINS-1:0] wake_rise;
	logic retain_wake;
	logic pd_wake;
	logic battery_ok;

	if (EXT_LINES < 1 || WAKE_PINS < 1) begin : g_bad_count
		$error("EXT_LINES and WAKE_PINS must be nonzero");
	end

	lpmc_edge_detect #(
		.WIDTH(WAKE_PINS)
	) u_wake_edge (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.level_i(wake_pin_i),
		.rise_o(wake_rise)
	);

	assign retain_wake = (|ext_event_line_i) | voltage_detector_out_i |
		rtc_event_i;
	assign pd_wake = ~ext_reset_pin_n_i | independent_watchdog_rst_i |
		(|wake_rise) | rtc_event_i;
	// Strap low means no supervisor, so no battery domain
	assign battery_ok = supervisor_strap_i;

	always_comb begin
		next_state = state;
		next_state.core_reset = 1'b0;
		// Backup switch follows main supply every cycle while the strap is high
		next_state.from_battery = ~main_supply_ok_i & battery_ok;
		next_state.battery_mode = ~main_supply_ok_i & battery_ok;
		if (~main_supply_ok_i & battery_ok) begin
			// Only main supply return or strap low ends battery operation
			next_state.mode = LPMC_POWERDOWN;
			next_state.cpu_clk_en = 1'b0;
			next_state.periph_clk_en = 1'b0;
			next_state.clk_src_en = 1'b0;
			next_state.regulator_on = 1'b0;
			next_state.retain_ok = 1'b0;
			next_state.flash_pwr = 1'b0;
		end else if (state.battery_mode) begin
			next_state.mode = LPMC_WAKE_RESET;
		end else begin
			unique case (state.mode)
				LPMC_RUN: begin
					if (wait_instr_i) begin
						if (mode_sel_i == LPMC_SEL_RETAIN) begin
							next_state.mode = LPMC_RETAIN;
							next_state.cpu_clk_en = 1'b0;
							next_state.periph_clk_en = 1'b0;
							next_state.clk_src_en = 1'b0;
							next_state.regulator_lp = regulator_lp_sel_i;
							next_state.retain_ok = 1'b1;
						end else if (mode_sel_i == LPMC_SEL_POWERDOWN &&
							!regulator_bypass_i) begin
							next_state.mode = LPMC_POWERDOWN;
							next_state.cpu_clk_en = 1'b0;
							next_state.periph_clk_en = 1'b0;
							next_state.clk_src_en = 1'b0;
							next_state.regulator_on = 1'b0;
							next_state.flash_pwr = 1'b0;
							next_state.retain_ok = 1'b0;
						end else begin
							// Bypassed power-down falls back to halt
							next_state.mode = LPMC_HALT;
							next_state.cpu_clk_en = 1'b0;
							// Flash may only drop while code runs from RAM
							next_state.flash_pwr = ~(flash_off_req_i &
								exec_from_ram_i);
						end
					end
				end
				LPMC_HALT: begin
					if (periph_irq_i | retain_wake) begin
						next_state.mode = LPMC_RUN;
						next_state.cpu_clk_en = 1'b1;
						next_state.flash_pwr = 1'b1;
					end
				end
				LPMC_RETAIN: begin
					if (retain_wake) begin
						next_state.mode = LPMC_RUN;
						next_state.cpu_clk_en = 1'b1;
						next_state.periph_clk_en = 1'b1;
						next_state.clk_src_en = 1'b1;
						next_state.regulator_lp = LPMC_RST_REGULATOR_LP;
						next_state.retain_ok = 1'b0;
					end
				end
				LPMC_POWERDOWN: begin
					if (pd_wake) begin
						next_state.mode = LPMC_WAKE_RESET;
						next_state.regulator_on = 1'b1;
						next_state.core_reset = 1'b1;
					end
				end
				LPMC_WAKE_RESET: begin
					// Core restarts from reset, contents gone
					next_state.mode = LPMC_RUN;
					next_state.cpu_clk_en = 1'b1;
					next_state.periph_clk_en = 1'b1;
					next_state.clk_src_en = 1'b1;
					next_state.regulator_on = 1'b1;
					next_state.regulator_lp = LPMC_RST_REGULATOR_LP;
					next_state.flash_pwr = 1'b1;
					next_state.core_reset = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state.mode <= LPMC_RUN;
			state.cpu_clk_en <= 1'b1;
			state.periph_clk_en <= 1'b1;
			state.clk_src_en <= 1'b1;
			state.regulator_on <= 1'b1;
			state.regulator_lp <= LPMC_RST_REGULATOR_LP;
			state.flash_pwr <= 1'b1;
			state.retain_ok <= 1'b0;
			state.core_reset <= 1'b0;
			state.from_battery <= 1'b0;
			state.battery_mode <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign cpu_clk_en_o = state.cpu_clk_en;
	assign periph_clk_en_o = state.periph_clk_en;
	assign pll_en_o = state.clk_src_en;
	assign internal_fast_rc_en_o = state.clk_src_en;
	assign crystal_osc_en_o = state.clk_src_en;
	assign regulator_on_o = state.regulator_on;
	assign regulator_lp_o = state.regulator_lp;
	assign flash_pwr_o = state.flash_pwr;
	assign retain_ok_o = state.retain_ok;
	assign core_reset_o = state.core_reset;
	assign backup_from_battery_o = state.from_battery;
	assign battery_mode_o = state.battery_mode;

	property p_halt_periph;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		state.mode == LPMC_HALT |-> periph_clk_en_o && !cpu_clk_en_o;
	endproperty
	a_halt_periph: assert property (p_halt_periph)
		else $error("halt mode clocks wrong");

	property p_halt_wake;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		state.mode == LPMC_HALT && periph_irq_i && main_supply_ok_i
		|=> cpu_clk_en_o;
	endproperty
	a_halt_wake: assert property (p_halt_wake)
		else $error("halt did not wake on interrupt");

	property p_retain_clk;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		state.mode == LPMC_RETAIN |-> !pll_en_o && !crystal_osc_en_o &&
			!internal_fast_rc_en_o && !periph_clk_en_o && retain_ok_o;
	endproperty
	a_retain_clk: assert property (p_retain_clk)
		else $error("retention left clocks running");

	property p_retain_wake;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		state.mode == LPMC_RETAIN && |ext_event_line_i && main_supply_ok_i
		&& !state.battery_mode |=> state.mode == LPMC_RUN;
	endproperty
	a_retain_wake: assert property (p_retain_wake)
		else $error("retention missed event line");

	property p_pd_off;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		state.mode == LPMC_POWERDOWN |-> !regulator_on_o && !pll_en_o;
	endproperty
	a_pd_off: assert property (p_pd_off)
		else $error("power-down left regulator on");

	property p_pd_exit;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		state.mode == LPMC_POWERDOWN && !ext_reset_pin_n_i && main_supply_ok_i
		&& !state.battery_mode |=> core_reset_o ##1 cpu_clk_en_o;
	endproperty
	a_pd_exit: assert property (p_pd_exit)
		else $error("power-down exit sequence wrong");

	property p_bypass;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		regulator_bypass_i && main_supply_ok_i && state.mode == LPMC_RUN
		|=> state.mode != LPMC_POWERDOWN;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("power-down entered while bypassed");

	property p_battery;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!main_supply_ok_i && supervisor_strap_i && !$past(main_supply_ok_i)
		&& $past(supervisor_strap_i)
		|-> battery_mode_o && backup_from_battery_o && !cpu_clk_en_o;
	endproperty
	a_battery: assert property (p_battery)
		else $error("battery operation broken");

	property p_strap;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!supervisor_strap_i |=> !battery_mode_o;
	endproperty
	a_strap: assert property (p_strap)
		else $error("battery mode with strap off");

	property p_entry;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		state.mode == LPMC_RUN && !wait_instr_i && main_supply_ok_i
		&& !state.battery_mode |=> state.mode == LPMC_RUN;
	endproperty
	a_entry: assert property (p_entry)
		else $error("low-power entry without wait instruction");
endmodule // lpmc_controller

// ### test/lpmc_core_model.sv
// Purpose: behavioural processor core issuing low-power entry requests
// Assumes: the bench launches one request at a time through go_i
// Notes: flash-off is only asked for while code runs from RAM
`timescale 1ns/100ps
module lpmc_core_model (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic go_i,
	input wire logic [1:0] sel_i,
	input wire logic from_ram_i,
	output logic wait_instr_o,
	output logic [1:0] mode_sel_o,
	output logic flash_off_req_o,
	output logic exec_from_ram_o
);
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wait_instr_o <= 1'h0;
			mode_sel_o <= 2'h0;
			flash_off_req_o <= 1'h0;
			exec_from_ram_o <= 1'h0;
		end else begin
			wait_instr_o <= go_i;
			if (go_i) begin
				mode_sel_o <= sel_i;
				exec_from_ram_o <= from_ram_i;
				// Flash may only drop while running from RAM
				flash_off_req_o <= from_ram_i;
			end
		end
	end
endmodule // lpmc_core_model

// ### test/low_power_mode_controller_test.sv
// Purpose: self-checking bench for the low-power mode controller
// Assumes: random seed fixed, inputs driven by NBA on the rising edge
// Notes: wake sources are held two cycles, then released
`timescale 1ns/100ps
module low_power_mode_controller_test;
	import lpmc_pkg::*;
	logic ref_clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic go = 1'h0;
	logic [1:0] sel = 2'h0;
	logic from_ram = 1'h0;
	logic wait_instr;
	logic flash_off_req;
	logic exec_from_ram;
	logic [1:0] mode_sel;
	logic lp_sel = 1'h0;
	logic irq = 1'h0;
	logic vdet = 1'h0;
	logic rtc = 1'h0;
	logic rst_n = 1'h1;
	logic wdg = 1'h0;
	logic bypass = 1'h0;
	logic main_ok = 1'h1;
	logic strap = 1'h1;
	logic [15:0] ext_line = 16'h0;
	logic [2:0] wake_pin = 3'h0;
	logic cpu_en, per_en, pll_en, rc_en, xo_en, reg_on, reg_lp, flash_pwr;
	logic retain_ok, core_reset, bkp_batt, batt_mode;
	logic saw_reset = 1'h0;
	int n_fail = 0;
	int tests_run = 0;

	always #20 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (core_reset === 1'h1) saw_reset <= 1'h1;

	lpmc_core_model core (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.go_i(go), .sel_i(sel), .from_ram_i(from_ram),
		.wait_instr_o(wait_instr), .mode_sel_o(mode_sel),
		.flash_off_req_o(flash_off_req), .exec_from_ram_o(exec_from_ram));

	lpmc_controller DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.wait_instr_i(wait_instr), .mode_sel_i(mode_sel),
		.regulator_lp_sel_i(lp_sel), .flash_off_req_i(flash_off_req),
		.exec_from_ram_i(exec_from_ram), .periph_irq_i(irq),
		.ext_event_line_i(ext_line), .voltage_detector_out_i(vdet),
		.rtc_event_i(rtc), .ext_reset_pin_n_i(rst_n),
		.independent_watchdog_rst_i(wdg), .wake_pin_i(wake_pin),
		.regulator_bypass_i(bypass), .main_supply_ok_i(main_ok),
		.supervisor_strap_i(strap), .cpu_clk_en_o(cpu_en),
		.periph_clk_en_o(per_en), .pll_en_o(pll_en),
		.internal_fast_rc_en_o(rc_en), .crystal_osc_en_o(xo_en),
		.regulator_on_o(reg_on), .regulator_lp_o(reg_lp),
		.flash_pwr_o(flash_pwr), .retain_ok_o(retain_ok),
		.core_reset_o(core_reset), .backup_from_battery_o(bkp_batt),
		.battery_mode_o(batt_mode));

	function automatic logic reg_up(input logic [1:0] s);
		return !(s == LPMC_SEL_POWERDOWN && !bypass);
	endfunction
	function automatic logic osc_on(input logic [1:0] s);
		return s != LPMC_SEL_RETAIN && reg_up(s);
	endfunction
	// Sources: 0 irq, 1 detector, 2 rtc, 3 line, 4 pin, 5 watchdog, 6 wake
	function automatic logic wakes(input logic [1:0] s, input int k);
		if (s == LPMC_SEL_RETAIN)
			return k >= 1 && k <= 3;
		if (!reg_up(s))
			return k == 2 || k >= 4;
		return k <= 3;
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic chk(input string what, input logic seen, input logic exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic raise(input int k);
		logic [31:0] rnd;
		rnd = $urandom;
		case (k)
			0: irq <= 1'h1;
			1: vdet <= 1'h1;
			2: rtc <= 1'h1;
			3: ext_line <= 16'h1 << rnd[3:0];
			4: rst_n <= 1'h0;
			5: wdg <= 1'h1;
			default: wake_pin <= 3'h1 << (rnd % 3);
		endcase
		step(2);
		{irq, vdet, rtc, wdg, ext_line, wake_pin} <= '0;
		rst_n <= 1'h1;
	endtask
	task automatic enter_chk(input logic [1:0] s);
		logic [31:0] rnd;
		rnd = $urandom;
		@(posedge ref_clk_i);
		{sel, lp_sel, from_ram, go} <= {s, rnd[1:0], 1'h1};
		@(posedge ref_clk_i);
		go <= 1'h0;
		saw_reset <= 1'h0;
		step(3);
		chk("cpu clock", cpu_en, 1'h0);
		chk("periph clock", per_en, osc_on(s));
		chk("pll", pll_en, osc_on(s));
		chk("fast rc", rc_en, osc_on(s));
		chk("crystal", xo_en, osc_on(s));
		chk("regulator", reg_on, reg_up(s));
		chk("retention", retain_ok, s == LPMC_SEL_RETAIN);
		chk("flash on", flash_pwr,
			s == LPMC_SEL_RETAIN || reg_up(s) && !from_ram);
		if (s == LPMC_SEL_RETAIN)
			chk("regulator lp", reg_lp, lp_sel);
	endtask
	task automatic wake_wait(input logic [1:0] s);
		int n;
		n = 0;
		while (cpu_en !== 1'h1 && n < 12) begin
			@(posedge ref_clk_i);
			n++;
		end
		chk("woken", cpu_en, 1'h1);
		step(4);
		chk("core reset", saw_reset, !reg_up(s));
		chk("flash", flash_pwr, 1'h1);
	endtask

	initial begin
		void'($urandom(32'h2CEF));
		step(5);
		sys_rst_i <= 1'h0;
		step(4);
		chk("idle cpu clock", cpu_en, 1'h1);
		chk("idle retention", retain_ok, 1'h0);
		for (int b = 0; b < 2; b++) begin
			bypass <= b[0];
			for (int s = 0; s < 4; s++) begin
				for (int k = 0; k < 7; k++) begin
					if (!wakes(s[1:0], k) && reg_up(s[1:0]))
						continue;
					enter_chk(s[1:0]);
					raise(k);
					if (!wakes(s[1:0], k)) begin
						step(4);
						chk("still down", cpu_en, 1'h0);
						raise(2);
					end
					wake_wait(s[1:0]);
				end
			end
		end
		// Battery: sources 0 to 3 (irq, detector, rtc, line) must not end it
		bypass <= 1'h0;
		main_ok <= 1'h0;
		saw_reset <= 1'h0;
		step(3);
		chk("battery", batt_mode, 1'h1);
		chk("backup from battery", bkp_batt, 1'h1);
		// A gap edge keeps one source release apart from the next raise
		for (int k = 0; k < 4; k++) begin
			raise(k);
			step(1);
		end
		step(3);
		chk("battery kept", batt_mode, 1'h1);
		main_ok <= 1'h1;
		step(2);
		chk("backup from main", bkp_batt, 1'h0);
		wake_wait(LPMC_SEL_POWERDOWN);
		// Strap low: no battery operation at all
		{strap, main_ok} <= 2'h0;
		step(3);
		chk("no battery", batt_mode, 1'h0);
		chk("no backup switch", bkp_batt, 1'h0);
		conclude;
	end

	initial begin
		step(5000);
		n_fail++;
		conclude;
	end
endmodule // low_power_mode_controller_test
